// [rtl/eabi_pkg.sv]
// constants for the external area bus interface
package eabi_pkg;
    // operating modes: 1 and 2 have a 1-Mbyte external space, 5 is the last expanded mode
    localparam logic [2:0] MODE_SMALL_LO = 3'h1;
    localparam logic [2:0] MODE_SMALL_HI = 3'h2;
    localparam logic [2:0] MODE_EXP_HI = 3'h5;
    // area number field position in each address space size
    localparam int AREA_LSB_SMALL = 17;
    localparam int AREA_LSB_LARGE = 21;
    localparam logic [23:0] TOP_SMALL = 24'h0FFFFF;
    localparam logic [23:0] TOP_LARGE = 24'hFFFFFF;
    // internal ranges: rom from 0, i/o at the top, ram just below i/o
    localparam logic [23:0] ROM_BYTES = 24'h020000;
    localparam logic [23:0] IO_BYTES = 24'h000100;
    localparam logic [23:0] RAM_BYTES = 24'h002000;
    // reset values of the two local registers
    localparam logic [7:0] ADDR_METHOD_RST = 8'hFF;
    localparam logic [7:0] SEL_OE_RST = 8'h0F;
    localparam int SEL_OE_LSB = 4;
    // access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1 = 3'h1,
        ST_T2 = 3'h3,
        ST_TW = 3'h2,
        ST_T3 = 3'h6
    } eabi_state_t;
endpackage

// [rtl/eabi_top.sv]
// external area bus interface: area selects, address method, alignment
`timescale 1ns/1ps
module eabi_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] op_mode,
    input wire logic rom_on,
    input wire logic internal_ram_on,
    input wire logic [7:0] area_width_bits,
    input wire logic [7:0] area_states_bits,
    input wire logic [15:0] area_wait_counts,
    input wire logic addr_method_we,
    input wire logic [7:0] addr_method_wdata,
    input wire logic sel_oe_we,
    input wire logic [7:0] sel_oe_wdata,
    input wire logic port_dir_we,
    input wire logic [3:0] port_dir_wdata,
    input wire logic req,
    input wire logic req_wr,
    input wire logic [1:0] req_size,
    input wire logic [23:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic [31:0] int_rdata,
    input wire logic [15:0] data_in,
    output logic busy,
    output logic done,
    output logic [31:0] rdata,
    output logic [7:0] addr_method_reg,
    output logic [7:0] select_output_enable_reg,
    output logic [3:0] port_dir_bits,
    output logic [23:0] ext_addr,
    output logic [7:0] area_select_n,
    output logic [7:0] area_select_oe,
    output logic rd_strobe_n,
    output logic upper_write_strobe_n,
    output logic lower_write_strobe_n,
    output logic [15:0] data_out,
    output logic data_oe_hi,
    output logic data_oe_lo
);
    typedef struct packed {
        eabi_pkg::eabi_state_t st;
        logic init;
        logic method;
        logic [3:0] seloe;
        logic [3:0] ddr;
        logic wr;
        logic [1:0] size;
        logic w8;
        logic three;
        logic [1:0] waits;
        logic [1:0] wload;
        logic [1:0] piece;
        logic [23:0] addr;
        logic [31:0] wsh;
        logic [31:0] rbuf;
        logic [31:0] rdata;
        logic done;
        logic [23:0] ext_addr;
        logic [7:0] cs_n;
        logic rd_n;
        logic hwr_n;
        logic lwr_n;
        logic [15:0] dout;
        logic oe_hi;
        logic oe_lo;
    } eabi_regs_t;

    eabi_regs_t s_r;
    eabi_regs_t s_nxt;

    function automatic logic expanded(input logic [2:0] m);
        expanded = (m >= eabi_pkg::MODE_SMALL_LO) &&
                   (m <= eabi_pkg::MODE_EXP_HI);
    endfunction

    function automatic logic [1:0] last_piece(input logic w8,
                                              input logic [1:0] sz);
        if (w8) begin
            last_piece = (sz == eabi_pkg::SZ_LONG) ? 2'h3 :
                         (sz == eabi_pkg::SZ_WORD) ? 2'h1 : 2'h0;
        end else begin
            last_piece = (sz == eabi_pkg::SZ_LONG) ? 2'h1 : 2'h0;
        end
    endfunction

    // address decode of the incoming request
    logic small_map;
    logic [23:0] top_addr;
    logic [23:0] top_ofs;
    logic [2:0] req_area;
    logic in_rom;
    logic in_ram;
    logic in_io;
    logic req_int;

    always_comb begin
        small_map = (op_mode == eabi_pkg::MODE_SMALL_LO) ||
                    (op_mode == eabi_pkg::MODE_SMALL_HI);
        top_addr = small_map ? eabi_pkg::TOP_SMALL : eabi_pkg::TOP_LARGE;
        top_ofs = top_addr - (req_addr & top_addr);
        // area size follows the map size
        req_area = small_map ? req_addr[eabi_pkg::AREA_LSB_SMALL +: 3] :
                               req_addr[eabi_pkg::AREA_LSB_LARGE +: 3];
        in_rom = rom_on && ((req_addr & top_addr) < eabi_pkg::ROM_BYTES);
        in_io = top_ofs < eabi_pkg::IO_BYTES;
        // ram range turns external when the ram is switched off
        in_ram = internal_ram_on &&
                 (top_ofs < (eabi_pkg::IO_BYTES + eabi_pkg::RAM_BYTES));
        // in expanded modes everything else in areas 0..7 is external
        req_int = !expanded(op_mode) || in_rom || in_ram || in_io;
    end

    always_comb begin
        logic [31:0] sh;
        logic [7:0] pbyte;
        logic [15:0] pword;
        logic [23:0] step;
        logic lastp;
        sh = s_r.wsh << {s_r.piece, 3'h0};
        pbyte = sh[31:24];
        pword = 16'((s_r.wsh << {s_r.piece, 4'h0}) >> 16);
        step = s_r.w8 ? 24'h000001 : 24'h000002;
        lastp = (s_r.piece == last_piece(s_r.w8, s_r.size));
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        // direction strap caught on the first edge after release
        if (!s_r.init) begin
            s_nxt.init = 1'b1;
            s_nxt.ddr[0] = expanded(op_mode) && !rom_on;
        end
        if (addr_method_we) begin
            s_nxt.method = addr_method_wdata[0];
        end
        // enable bits frozen in single-chip mode
        if (sel_oe_we && expanded(op_mode)) begin
            s_nxt.seloe = sel_oe_wdata[7:4];
        end
        if (port_dir_we) begin
            s_nxt.ddr = port_dir_wdata;
        end
        case (s_r.st)
            eabi_pkg::ST_IDLE: begin
                if (req) begin
                    s_nxt.wr = req_wr;
                    s_nxt.size = req_size;
                    s_nxt.addr = req_addr;
                    s_nxt.piece = 2'h0;
                    s_nxt.rbuf = 32'h0;
                    s_nxt.w8 = area_width_bits[req_area];
                    s_nxt.three = area_states_bits[req_area];
                    s_nxt.waits = area_wait_counts[{req_area, 1'b0} +: 2];
                    s_nxt.wload = area_wait_counts[{req_area, 1'b0} +: 2];
                    // left-justify so pieces leave most significant first
                    s_nxt.wsh = (req_size == eabi_pkg::SZ_BYTE) ?
                                (req_wdata << 24) :
                                (req_size == eabi_pkg::SZ_WORD) ?
                                (req_wdata << 16) : req_wdata;
                    if (req_int) begin
                        // no select falls for internal targets
                        s_nxt.rdata = int_rdata;
                        s_nxt.done = 1'b1;
                        if (s_r.method) begin
                            s_nxt.ext_addr = req_addr;
                        end
                        // method 2 keeps the last external address
                    end else begin
                        s_nxt.st = eabi_pkg::ST_T1;
                        s_nxt.ext_addr = req_addr;
                        s_nxt.cs_n = ~(8'h01 << req_area);
                    end
                end
            end
            eabi_pkg::ST_T1: begin
                s_nxt.st = eabi_pkg::ST_T2;
                if (!s_r.wr) begin
                    s_nxt.rd_n = 1'b0;
                end else if (s_r.w8) begin
                    // upper strobe only, lower lane carries a copy of the byte
                    s_nxt.dout = {pbyte, pbyte};
                    s_nxt.oe_hi = 1'b1;
                    s_nxt.oe_lo = 1'b1;
                    s_nxt.hwr_n = 1'b0;
                end else if (s_r.size == eabi_pkg::SZ_BYTE) begin
                    s_nxt.dout = {pbyte, pbyte};
                    s_nxt.oe_hi = 1'b1;
                    s_nxt.oe_lo = 1'b1;
                    s_nxt.hwr_n = s_r.addr[0];
                    s_nxt.lwr_n = !s_r.addr[0];
                end else begin
                    s_nxt.dout = pword;
                    s_nxt.oe_hi = 1'b1;
                    s_nxt.oe_lo = 1'b1;
                    s_nxt.hwr_n = 1'b0;
                    s_nxt.lwr_n = 1'b0;
                end
            end
            eabi_pkg::ST_T2, eabi_pkg::ST_TW, eabi_pkg::ST_T3: begin
                if (s_r.st == eabi_pkg::ST_TW) begin
                    s_nxt.waits = s_r.waits - 2'h1;
                    if (s_r.waits == 2'h1) begin
                        s_nxt.st = eabi_pkg::ST_T3;
                    end
                end else if (s_r.st == eabi_pkg::ST_T2 && s_r.three) begin
                    s_nxt.st = (s_r.waits != 2'h0) ? eabi_pkg::ST_TW :
                                                     eabi_pkg::ST_T3;
                end else begin
                    // piece ends: sample only the lanes carrying data
                    if (!s_r.wr) begin
                        if (s_r.w8) begin
                            s_nxt.rbuf = {s_r.rbuf[23:0], data_in[15:8]};
                        end else if (s_r.size == eabi_pkg::SZ_BYTE) begin
                            s_nxt.rbuf = {s_r.rbuf[23:0], s_r.addr[0] ?
                                          data_in[7:0] : data_in[15:8]};
                        end else begin
                            s_nxt.rbuf = {s_r.rbuf[15:0], data_in};
                        end
                    end
                    s_nxt.rd_n = 1'b1;
                    s_nxt.hwr_n = 1'b1;
                    s_nxt.lwr_n = 1'b1;
                    s_nxt.oe_hi = 1'b0;
                    s_nxt.oe_lo = 1'b0;
                    if (lastp) begin
                        s_nxt.st = eabi_pkg::ST_IDLE;
                        s_nxt.cs_n = 8'hFF;
                        s_nxt.rdata = s_nxt.rbuf;
                        s_nxt.done = 1'b1;
                    end else begin
                        // select stays low across split pieces
                        s_nxt.st = eabi_pkg::ST_T1;
                        s_nxt.piece = s_r.piece + 2'h1;
                        s_nxt.addr = s_r.addr + step;
                        s_nxt.ext_addr = s_r.addr + step;
                        // the count ran down in the last piece; reload it
                        s_nxt.waits = s_r.wload;
                    end
                end
            end
            default: begin
                s_nxt.st = eabi_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= eabi_pkg::ST_IDLE;
            s_r.method <= eabi_pkg::ADDR_METHOD_RST[0];
            s_r.seloe <= eabi_pkg::SEL_OE_RST[7:4];
            s_r.three <= 1'b1;
            s_r.rd_n <= 1'b1;
            s_r.hwr_n <= 1'b1;
            s_r.lwr_n <= 1'b1;
            s_r.cs_n <= 8'hFF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // select pins: 0..3 gated by direction, 4..7 by their enables
    logic [7:0] oe_nxt;
    assign oe_nxt = {s_nxt.seloe, s_nxt.ddr & {4{expanded(op_mode)}}};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            area_select_oe <= 8'h00;
        end else begin
            area_select_oe <= oe_nxt;
        end
    end

    assign busy = (s_r.st != eabi_pkg::ST_IDLE);
    assign done = s_r.done;
    assign rdata = s_r.rdata;
    // reserved bits read as ones
    assign addr_method_reg = {7'h7F, s_r.method};
    localparam logic [3:0] SEL_LOW = eabi_pkg::SEL_OE_RST[3:0];
    assign select_output_enable_reg = {s_r.seloe, SEL_LOW};
    assign port_dir_bits = s_r.ddr;
    assign ext_addr = s_r.ext_addr;
    assign area_select_n = s_r.cs_n;
    assign rd_strobe_n = s_r.rd_n;
    assign upper_write_strobe_n = s_r.hwr_n;
    assign lower_write_strobe_n = s_r.lwr_n;
    assign data_out = s_r.dout;
    assign data_oe_hi = s_r.oe_hi;
    assign data_oe_lo = s_r.oe_lo;

    a_internal_cs_high: assert property (
        @(posedge ref_clk) disable iff (rst)
        (s_r.st == eabi_pkg::ST_IDLE && req && req_int)
        |=> (area_select_n == 8'hFF) && done)
        else $error("select fell on an internal access");

    a_cs_with_addr: assert property (
        @(posedge ref_clk) disable iff (rst)
        (s_r.st == eabi_pkg::ST_IDLE && req && !req_int)
        |=> !area_select_n[$past(req_area)] &&
            (ext_addr == $past(req_addr)))
        else $error("select and address not launched together");

    a_method1_update: assert property (
        @(posedge ref_clk) disable iff (rst)
        (s_r.st == eabi_pkg::ST_IDLE && req && req_int && s_r.method)
        |=> ext_addr == $past(req_addr))
        else $error("address not updated in method 1");

    a_method2_hold: assert property (
        @(posedge ref_clk) disable iff (rst)
        (s_r.st == eabi_pkg::ST_IDLE && req && req_int && !s_r.method)
        |=> $stable(ext_addr))
        else $error("address moved on internal access in method 2");

    a_upper_enables: assert property (
        @(posedge ref_clk) disable iff (rst)
        sel_oe_we && expanded(op_mode)
        |=> area_select_oe[7:4] == $past(sel_oe_wdata[7:4]))
        else $error("select enable not applied");

    a_narrow_upper: assert property (
        @(posedge ref_clk) disable iff (rst)
        (s_r.st == eabi_pkg::ST_T1 && s_r.w8)
        |=> lower_write_strobe_n)
        else $error("lower strobe used on 8-bit area");

    a_word_both: assert property (
        @(posedge ref_clk) disable iff (rst)
        (s_r.st == eabi_pkg::ST_T1 && s_r.wr && !s_r.w8 &&
         s_r.size != eabi_pkg::SZ_BYTE)
        |=> !upper_write_strobe_n && !lower_write_strobe_n)
        else $error("word write lacks both strobes");

    a_odd_lane: assert property (
        @(posedge ref_clk) disable iff (rst)
        (s_r.st == eabi_pkg::ST_T1 && s_r.wr && !s_r.w8 &&
         s_r.size == eabi_pkg::SZ_BYTE)
        |=> (upper_write_strobe_n == $past(s_r.addr[0])) &&
            (lower_write_strobe_n == !$past(s_r.addr[0])))
        else $error("byte lane does not follow address parity");

    a_read_strobe: assert property (
        @(posedge ref_clk) disable iff (rst)
        (s_r.st == eabi_pkg::ST_T1 && !s_r.wr)
        |=> !rd_strobe_n && upper_write_strobe_n && lower_write_strobe_n)
        else $error("read strobe wrong");
endmodule

// [dv/eabi_mem_model.sv]
// external sram model hanging off the area selects and both lanes
`timescale 1ns/1ps
module eabi_mem_model (
    input wire logic ref_clk,
    input wire logic [23:0] ext_addr,
    input wire logic [7:0] area_select_n,
    input wire logic [7:0] area_width_bits,
    input wire logic rd_strobe_n,
    input wire logic upper_write_strobe_n,
    input wire logic lower_write_strobe_n,
    input wire logic [15:0] data_out,
    output logic [15:0] data_in
);
    logic [7:0] mem [logic [23:0]];
    logic [15:0] last = 16'h0000;
    logic narrow;
    logic rding;
    logic [23:0] ev;
    // area field of the 1-Mbyte map only
    assign narrow = area_width_bits[ext_addr[19:17]];
    assign ev = {ext_addr[23:1], 1'b0};
    assign rding = !rd_strobe_n && area_select_n != 8'hFF;
    function automatic logic [7:0] rd8(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : 8'hA5;
    endfunction
    always @(posedge ref_clk) begin
        if (!upper_write_strobe_n)
            mem[narrow ? ext_addr : ev] = data_out[15:8];
        if (!lower_write_strobe_n)
            mem[ev | 24'h000001] = data_out[7:0];
        if (rding)
            last <= data_in;
    end
    // released bus shows inverted last value, never a stale match
    always @* begin
        if (rding && narrow)
            data_in = {rd8(ext_addr), ~last[7:0]};
        else if (rding)
            data_in = {rd8(ev), rd8(ev | 24'h000001)};
        else
            data_in = ~last;
    end
endmodule

// [dv/eabi_top_tb.sv]
// self-checking bench for the external area bus interface
`timescale 1ns/1ps
module eabi_top_tb;
    logic ref_clk, rst, rom_on, internal_ram_on, req, req_wr;
    logic addr_method_we, sel_oe_we, port_dir_we, busy, done;
    logic rd_strobe_n, upper_write_strobe_n, lower_write_strobe_n;
    logic data_oe_hi, data_oe_lo;
    logic [7:0] addr_method_wdata, sel_oe_wdata, addr_method_reg;
    logic [7:0] select_output_enable_reg, area_select_n, area_select_oe;
    logic [7:0] sel_and;
    logic [3:0] port_dir_wdata, port_dir_bits;
    logic [1:0] req_size;
    logic [23:0] req_addr, ext_addr;
    logic [31:0] req_wdata, int_rdata, rdata;
    logic [15:0] data_in, data_out;
    int failures = 0;
    int checks = 0;
    int hw_n, lw_n;
    // area 2 is 8-bit, area 3 three-state with two waits
    localparam logic [7:0] WIDTHS = 8'h04;

    eabi_top dut_u (.op_mode(3'h1), .area_width_bits(WIDTHS),
        .area_states_bits(8'h08), .area_wait_counts(16'h0080), .*);
    eabi_mem_model mem_u (.area_width_bits(WIDTHS), .*);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        sel_and <= sel_and & area_select_n;
        if (!upper_write_strobe_n)
            hw_n <= hw_n + 1;
        if (!lower_write_strobe_n)
            lw_n <= lw_n + 1;
    end

    task automatic tally_and_finish;
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chki(input string nm, input int e, input int g);
        checks++;
        if (g != e) begin
            failures++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // one whole access; hw < 0 skips the strobe counts
    task automatic acc(input logic wr, input logic [1:0] sz,
            input logic [23:0] a, input logic [31:0] d, input int lat,
            input logic [7:0] sel, input int hw, input int lw);
        int n;
        logic [31:0] m;
        m = sz == eabi_pkg::SZ_BYTE ? 32'h000000FF :
            sz == eabi_pkg::SZ_WORD ? 32'h0000FFFF : 32'hFFFFFFFF;
        @(posedge ref_clk);
        #1;
        req = 1'b1;
        req_wr = wr;
        req_size = sz;
        req_addr = a;
        req_wdata = d & m;
        sel_and = 8'hFF;
        hw_n = 0;
        lw_n = 0;
        // internal answers come on the taking edge itself
        for (n = 1; n < 60; n++) begin
            @(posedge ref_clk);
            #1;
            if (n == 1)
                req = 1'b0;
            if (done === 1'b1)
                break;
        end
        if (n == 60) begin
            failures++;
            tally_and_finish();
        end
        chki("latency", lat, n);
        chk("selects", {24'h0, sel}, {24'h0, sel_and});
        if (hw >= 0) begin
            chki("upper_strobes", hw, hw_n);
            chki("lower_strobes", lw, lw_n);
        end
        if (!wr)
            chk("rdata", d & m, rdata & m);
    endtask

    task automatic do_reset;
        rst = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        rom_on = 1'b0;
        internal_ram_on = 1'b1;
        req = 1'b0;
        req_wr = 1'b0;
        req_size = 2'h0;
        req_addr = 24'h0;
        req_wdata = 32'h0;
        int_rdata = 32'h1234ABCD;
        addr_method_we = 1'b0;
        addr_method_wdata = 8'h00;
        sel_oe_we = 1'b0;
        sel_oe_wdata = 8'hF0;
        port_dir_we = 1'b0;
        port_dir_wdata = 4'hF;
        do_reset();
        chk("method_reg", 32'hFF, {24'h0, addr_method_reg});
        chk("sel_oe_reg", 32'h0F, {24'h0, select_output_enable_reg});
        chk("select_oe", 32'h01, {24'h0, area_select_oe});
        sel_oe_we = 1'b1;
        port_dir_we = 1'b1;
        @(posedge ref_clk);
        #1;
        sel_oe_we = 1'b0;
        port_dir_we = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("select_oe", 32'hFF, {24'h0, area_select_oe});
        for (int k = 0; k < 8; k++)
            acc(1'b1, 2'h0, 24'(k) << 17, 32'h11, k == 3 ? 6 : 3,
                ~(8'h01 << k), k == 3 ? -1 : 1, 0);
        acc(1'b1, 2'h1, 24'h020010, 32'hBEEF, 3, 8'hFD, 1, 1);
        acc(1'b0, 2'h1, 24'h020010, 32'hBEEF, 3, 8'hFD, 0, 0);
        acc(1'b1, 2'h0, 24'h020013, 32'h5A, 3, 8'hFD, 0, 1);
        acc(1'b0, 2'h1, 24'h020012, 32'hA55A, 3, 8'hFD, 0, 0);
        acc(1'b1, 2'h2, 24'h020020, 32'h12345678, 5, 8'hFD, 2, 2);
        acc(1'b0, 2'h2, 24'h020020, 32'h12345678, 5, 8'hFD, 0, 0);
        acc(1'b1, 2'h2, 24'h040000, 32'hCAFEF00D, 9, 8'hFB, 4, 0);
        acc(1'b0, 2'h2, 24'h040000, 32'hCAFEF00D, 9, 8'hFB, 0, 0);
        acc(1'b1, 2'h1, 24'h060000, 32'h1357, 6, 8'hF7, -1, -1);
        acc(1'b0, 2'h1, 24'h060000, 32'h1357, 6, 8'hF7, -1, -1);
        acc(1'b0, 2'h2, 24'h0FFF00, int_rdata, 1, 8'hFF, 0, 0);
        acc(1'b0, 2'h0, 24'h0FDF00, int_rdata, 1, 8'hFF, 0, 0);
        internal_ram_on = 1'b0;
        acc(1'b1, 2'h0, 24'h0FDF00, 32'h77, 3, 8'h7F, 1, 0);
        addr_method_wdata = 8'h00;
        addr_method_we = 1'b1;
        @(posedge ref_clk);
        #1;
        addr_method_we = 1'b0;
        chk("method_reg", 32'hFE, {24'h0, addr_method_reg});
        acc(1'b1, 2'h1, 24'h020040, 32'h2468, 3, 8'hFD, 1, 1);
        acc(1'b0, 2'h2, 24'h0FFF08, int_rdata, 1, 8'hFF, 0, 0);
        chk("ext_addr", 32'h020040, {8'h0, ext_addr});
        addr_method_wdata = 8'h01;
        addr_method_we = 1'b1;
        @(posedge ref_clk);
        #1;
        addr_method_we = 1'b0;
        acc(1'b0, 2'h2, 24'h0FFF08, int_rdata, 1, 8'hFF, 0, 0);
        chk("ext_addr", 32'h0FFF08, {8'h0, ext_addr});
        rom_on = 1'b1;
        do_reset();
        chk("select_oe", 32'h00, {24'h0, area_select_oe});
        acc(1'b0, 2'h0, 24'h000100, int_rdata, 1, 8'hFF, 0, 0);
        acc(1'b1, 2'h0, 24'h020100, 32'h99, 3, 8'hFD, 1, 0);
        tally_and_finish();
    end
endmodule
